// ### core/uart_irq_baud.sv
// Purpose: Interrupt enable/identification and baud generator of a serial port, APB slave
// Assumes: ref_tick is a one-cycle strobe at the 24 MHz reference rate, synchronous to clk
// Notes: Every access takes one access cycle; register map in the package
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module uart_irq_baud
   import uart_irq_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ref_tick,
   input wire logic line_error,
   input wire logic line_status_read,
   input wire logic rx_ready_level,
   input wire logic rx_data_present,
   input wire logic rx_fifo_access,
   input wire logic tx_holding_empty,
   input wire logic tx_holding_write,
   input wire logic [3:0] modem_changed,
   output logic baud16_tick,
   output logic uart_irq,
   output logic event_irq
);
   state_s q, d;
   logic setup, access, wr_en, rd_en;
   logic [7:0] addr;
   logic [3:0] id_code;
   logic [7:0] id_byte;
   logic [3:0] ev_set;
   logic [6:0] frac_mod, frac_sum;
   logic pre_tick;
   logic [15:0] divisor, div_eff;
   logic src_lerr, src_rx, src_to, src_tx, src_modem;
   logic [31:0] rd_word;
   logic rd_ok;

   default clocking chk_cb @(posedge clk);
   endclocking
   default disable iff (srst);

   always_comb begin
      d = q;
      setup = psel & ~penable;
      access = psel & penable & q.pready;
      wr_en = access & pwrite;
      rd_en = access & ~pwrite;
      addr = paddr[7:0];
      divisor = {q.dlm, q.dll}; // R11
      div_eff = (divisor == 16'h0000) ? 16'h0001 : divisor; // R10

      // Enabled sources in priority order
      src_lerr = q.lerr_pend & q.ier[EN_LERR]; // R06
      src_rx = rx_ready_level & q.ier[EN_RX]; // R08
      src_to = q.to_pend & q.cfg[CFG_FIFO_EN] & q.ier[EN_RX]; // R03 R08
      src_tx = q.thre_pend & q.ier[EN_TX]; // R07
      src_modem = (|modem_changed) & q.ier[EN_MODEM]; // R02 R05
      if (src_lerr) begin
         id_code = ID_LERR; // R16 R18
      end else if (src_rx) begin
         id_code = ID_RX; // R16
      end else if (src_to) begin
         id_code = ID_TIMEOUT; // R16
      end else if (src_tx) begin
         id_code = ID_TX; // R01
      end else if (src_modem) begin
         id_code = ID_MODEM; // R02
      end else begin
         id_code = ID_NONE; // R09 R18
      end
      id_byte = {(q.cfg[CFG_FIFO_EN] ? ID_FIFO_MARK : 2'h0), 2'h0, id_code};

      // Read mux, prepared in the setup cycle so that prdata is a flop
      rd_ok = 1'b1;
      case (addr)
         ADDR_IER: rd_word = {28'h0, q.ier}; // R04
         ADDR_DLL: rd_word = {24'h0, q.dll};
         ADDR_DLM: rd_word = {24'h0, q.dlm};
         ADDR_SCR: rd_word = {24'h0, q.scr}; // R14
         ADDR_IIR: rd_word = {24'h0, id_byte};
         ADDR_CFG: rd_word = {26'h0, q.cfg};
         ADDR_EVS: rd_word = {28'h0, q.ev_status};
         ADDR_EVM: rd_word = {28'h0, q.ev_mask};
         default: begin
            rd_word = 32'h0;
            rd_ok = 1'b0;
         end
      endcase
      d.pready = setup;
      d.pslverr = setup & ~rd_ok;
      d.prdata = (setup & ~pwrite) ? rd_word : 32'h0;

      if (wr_en) begin
         case (addr)
            ADDR_IER: d.ier = pwdata[3:0]; // R04
            ADDR_DLL: d.dll = pwdata[7:0]; // R11
            ADDR_DLM: d.dlm = pwdata[7:0]; // R11
            ADDR_SCR: d.scr = pwdata[7:0]; // R14
            ADDR_CFG: d.cfg = pwdata[5:0];
            ADDR_EVM: d.ev_mask = pwdata[3:0];
            default: ;
         endcase
      end

      // Transmit empty: set on rising empty, cleared by new data or by an ident read that showed it
      // The held read word is what the host sees, so a source change during access cannot clear it
      d.tx_empty_prev = tx_holding_empty;
      if (tx_holding_write || (rd_en && addr == ADDR_IIR && q.prdata[3:0] == ID_TX)) begin
         d.thre_pend = 1'b0; // R01
      end
      if (tx_holding_empty & ~q.tx_empty_prev) begin
         d.thre_pend = 1'b1; // R01
      end

      // Line error pending; a new error in the clear cycle wins
      if (line_status_read) begin
         d.lerr_pend = 1'b0;
      end
      if (line_error) begin
         d.lerr_pend = 1'b1; // R16
      end

      // Timeout: four character times of baud ticks with data and no FIFO access
      if (rx_fifo_access || !rx_data_present || !q.cfg[CFG_FIFO_EN]) begin
         d.to_cnt = 10'h0; // R03 R16
         d.to_pend = 1'b0;
      end else if (q.baud16 && q.to_cnt != TIMEOUT_TICKS) begin
         d.to_cnt = q.to_cnt + 10'h1;
         if (q.to_cnt + 10'h1 == TIMEOUT_TICKS) begin
            d.to_pend = 1'b1; // R16
         end
      end

      // Pre-divider as fractional accumulator: modulus/8 reference ticks per step
      case (q.cfg[CFG_PRE_LO +: 2])
         PRE_13: frac_mod = FRAC_MOD_13; // R15
         PRE_1P625: frac_mod = FRAC_MOD_1P625; // R15
         default: frac_mod = FRAC_MOD_1P0; // R15
      endcase
      pre_tick = 1'b0;
      frac_sum = q.frac_acc + FRAC_STEP;
      if (q.cfg[CFG_HS_LO +: 2] == HS_ON) begin
         pre_tick = ref_tick; // R13
         d.frac_acc = 7'h0;
      end else if (ref_tick) begin
         if (frac_sum >= frac_mod) begin
            d.frac_acc = frac_sum - frac_mod; // R10
            pre_tick = 1'b1;
         end else begin
            d.frac_acc = frac_sum;
         end
      end

      // Divisor counter gives the 16x pulse to transmitter and receiver
      d.baud16 = 1'b0;
      if (pre_tick) begin
         if (q.div_cnt + 16'h1 >= div_eff) begin
            d.div_cnt = 16'h0; // R10 R12
            d.baud16 = 1'b1; // R12
         end else begin
            d.div_cnt = q.div_cnt + 16'h1;
         end
      end

      // Sticky event status, write one to clear; a set in the same cycle wins
      ev_set = 4'h0;
      ev_set[EV_LERR] = line_error;
      ev_set[EV_TIMEOUT] = d.to_pend & ~q.to_pend;
      ev_set[EV_TX] = tx_holding_empty & ~q.tx_empty_prev;
      ev_set[EV_MODEM] = |modem_changed;
      if (wr_en && addr == ADDR_EVS) begin
         d.ev_status = q.ev_status & ~pwdata[3:0];
      end
      d.ev_status = d.ev_status | ev_set;
      d.event_irq = |(d.ev_status & d.ev_mask);

      // Interrupt pin: any enabled pending source, gated by the control bit
      d.uart_irq = (id_code != ID_NONE) & q.cfg[CFG_PIN_EN]; // R09 R17 R18
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         q <= '0;
         q.dll <= DIV_RESET[7:0];
         q.dlm <= DIV_RESET[15:8];
      end else begin
         q <= d;
      end
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign baud16_tick = q.baud16;
   assign uart_irq = q.uart_irq;
   assign event_irq = q.event_irq;

   // Checks
   ier_upper_zero_a: assert property (@(posedge clk) disable iff (srst) // R04
      (rd_en && addr == ADDR_IER) |-> prdata[7:4] == 4'h0)
      else $error("enable register upper bits not zero");
   timeout_fifo_a: assert property (@(posedge clk) disable iff (srst) // R03
      (rd_en && addr == ADDR_IIR && !q.cfg[CFG_FIFO_EN]) |-> prdata[3] == 1'b0)
      else $error("timeout bit set outside FIFO mode");
   all_masked_a: assert property (@(posedge clk) disable iff (srst) // R09
      (q.ier == 4'h0) |=> !uart_irq)
      else $error("interrupt with all enables clear");
   pin_gate_a: assert property (@(posedge clk) disable iff (srst) // R17
      !q.cfg[CFG_PIN_EN] |=> !uart_irq)
      else $error("interrupt pin active while gated off");
   lerr_first_a: assert property (@(posedge clk) disable iff (srst) // R16
      (q.lerr_pend && q.ier[EN_LERR]) |-> id_code == ID_LERR)
      else $error("line error not reported first");
   tx_clear_a: assert property (@(posedge clk) disable iff (srst) // R01
      (tx_holding_write && !(tx_holding_empty && !q.tx_empty_prev)) |=> !q.thre_pend)
      else $error("transmit empty not cleared by write");
   modem_mask_a: assert property (@(posedge clk) disable iff (srst) // R05
      (!q.ier[EN_MODEM] && id_code == ID_MODEM) |-> 1'b0)
      else $error("masked modem change reported");
   idle_bit0_a: assert property (@(posedge clk) disable iff (srst) // R18
      (id_code[0] == 1'b1) |-> !(src_lerr || src_rx || src_to || src_tx || src_modem))
      else $error("ident idle while source pending");
   baud_rate_a: assert property (@(posedge clk) disable iff (srst) // R13
      (q.cfg[CFG_HS_LO +: 2] == HS_ON && divisor == 16'h0001 && ref_tick && $stable(q.cfg)) |=> baud16_tick)
      else $error("high speed divide by one missed tick");
   scratch_rb_a: assert property (@(posedge clk) disable iff (srst) // R14
      (wr_en && addr == ADDR_SCR) |=> q.scr == $past(pwdata[7:0]))
      else $error("scratch write lost");
   tx_set_a: assert property ( // R01
      (tx_holding_empty && !q.tx_empty_prev) |=> q.thre_pend)
      else $error("transmit empty not set on rising edge");
   tx_read_clear_a: assert property ( // R01
      (rd_en && addr == ADDR_IIR && prdata[3:0] == ID_TX && !(tx_holding_empty && !q.tx_empty_prev))
      |=> !q.thre_pend)
      else $error("transmit empty not cleared by ident read");
   tx_third_a: assert property ( // R01
      (src_tx && !src_lerr && !src_rx && !src_to) |-> id_code == ID_TX)
      else $error("transmit empty not reported third");
   modem_fourth_a: assert property ( // R02
      (src_modem && !src_lerr && !src_rx && !src_to && !src_tx) |-> id_code == ID_MODEM)
      else $error("modem change not reported fourth");
   modem_source_a: assert property ( // R02 R05
      ((|modem_changed) && q.ier[EN_MODEM]) |-> id_code != ID_NONE)
      else $error("enabled modem change not pending");
   timeout_bit_a: assert property ( // R03
      !q.cfg[CFG_FIFO_EN] |-> !id_code[3])
      else $error("timeout code outside FIFO mode");
   ier_write_a: assert property ( // R04
      (wr_en && addr == ADDR_IER) |=> q.ier == $past(pwdata[3:0]))
      else $error("enable register write lost");
   lerr_mask_a: assert property ( // R06
      !q.ier[EN_LERR] |-> id_code != ID_LERR)
      else $error("masked line error reported");
   tx_mask_a: assert property ( // R07
      !q.ier[EN_TX] |-> id_code != ID_TX)
      else $error("masked transmit empty reported");
   rx_mask_a: assert property ( // R08
      !q.ier[EN_RX] |-> (id_code != ID_RX && id_code != ID_TIMEOUT))
      else $error("masked receive source reported");
   div_wrap_a: assert property ( // R10 R12
      (pre_tick && q.div_cnt == div_eff - 16'h1) |=> baud16_tick)
      else $error("divisor end without baud pulse");
   div_write_a: assert property ( // R11
      (wr_en && addr == ADDR_DLM) |=> q.dlm == $past(pwdata[7:0]))
      else $error("divisor high byte write lost");
   baud_gap_a: assert property ( // R12
      !pre_tick |=> !baud16_tick)
      else $error("baud pulse without reference step");
   high_speed_a: assert property ( // R13
      (q.cfg[CFG_HS_LO +: 2] == HS_ON) |-> pre_tick == ref_tick)
      else $error("high speed does not bypass pre-divider");
   scratch_side_a: assert property ( // R14
      (wr_en && addr == ADDR_SCR) |=> ($stable(q.ier) && $stable(q.cfg) && $stable(divisor)))
      else $error("scratch write disturbed port state");
   pre_one_a: assert property ( // R15
      (q.cfg[CFG_HS_LO +: 2] != HS_ON && frac_mod == FRAC_MOD_1P0 && q.frac_acc < FRAC_MOD_1P0)
      |-> pre_tick == ref_tick)
      else $error("unit pre-divider dropped a step");
   pre_slow_a: assert property ( // R15
      (q.cfg[CFG_PRE_LO +: 2] == PRE_13 && q.cfg[CFG_HS_LO +: 2] != HS_ON && pre_tick && !wr_en) |=> !pre_tick)
      else $error("pre-divider of 13 stepped twice in a row");
   lerr_set_a: assert property ( // R16
      line_error |=> q.lerr_pend)
      else $error("line error not pending");
   rx_second_a: assert property ( // R16
      (src_rx && !src_lerr) |-> id_code == ID_RX)
      else $error("receive ready not reported second");
   timeout_count_a: assert property ( // R16
      $rose(q.to_pend) |-> q.to_cnt == TIMEOUT_TICKS)
      else $error("timeout fired at wrong count");
   pin_irq_a: assert property ( // R17 R18
      (q.cfg[CFG_PIN_EN] && id_code != ID_NONE) |=> uart_irq)
      else $error("pending source without interrupt");
   event_set_a: assert property (
      (wr_en && addr == ADDR_EVS && line_error) |=> q.ev_status[EV_LERR])
      else $error("event clear beat a new event");
   ready_pulse_a: assert property (
      pready |=> !pready)
      else $error("ready high for two cycles");
   read_idle_a: assert property (
      !pready |-> prdata == 32'h0)
      else $error("read data outside access");

   irq_seen_c: cover property (@(posedge clk) disable iff (srst) $rose(uart_irq));
   timeout_seen_c: cover property (@(posedge clk) disable iff (srst) $rose(q.to_pend));
   baud_seen_c: cover property (@(posedge clk) disable iff (srst) baud16_tick ##1 !baud16_tick);
   slverr_seen_c: cover property (@(posedge clk) disable iff (srst) pready && pslverr);
   tx_read_clear_c: cover property (rd_en && addr == ADDR_IIR && prdata[3:0] == ID_TX);
endmodule : uart_irq_baud
`default_nettype wire

// ### core/uart_irq_pkg.sv
// Purpose: Constants, register map and state layout for the serial port interrupt and baud logic
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes: Only the low byte of each register is used
// Notes on behaviour
// R01: Transmit empty is third priority, cleared by write/ident read
// R02: Modem change is fourth priority, cleared by status read
// R03: Timeout bit set only in FIFO mode
// R04: Enable register upper four bits read zero
// R05: Enable bit 3 unmasks modem change source
// R06: Enable bit 2 unmasks receive line errors
// R07: Enable bit 1 unmasks transmit holding empty
// R08: Enable bit 0 unmasks receive ready and timeout
// R09: All enables clear means no interrupt on uart_irq; event_irq does not use the enables
// R10: Normal speed divides reference by divisor, minimum one
// R11: Two byte registers form sixteen bit divisor
// R12: Baud output pulses at sixteen times bit rate
// R13: High speed applies divisor to raw input clock
// R14: Scratch register reads back freely, no side effect
// R15: Pre-divider selectable: 13, 1.625 or 1.0
// R16: Line errors first, receive ready/timeout second
// R17: Control bit gates interrupt output pin overall
// R18: Identification encodes highest pending; bit 0 high when idle
package uart_irq_pkg;
   localparam logic [7:0] ADDR_IER = 8'h00;
   localparam logic [7:0] ADDR_DLL = 8'h04;
   localparam logic [7:0] ADDR_DLM = 8'h08;
   localparam logic [7:0] ADDR_SCR = 8'h0c;
   localparam logic [7:0] ADDR_IIR = 8'h10;
   localparam logic [7:0] ADDR_CFG = 8'h14;
   localparam logic [7:0] ADDR_EVS = 8'h18;
   localparam logic [7:0] ADDR_EVM = 8'h1c;
   localparam int EN_RX = 0;
   localparam int EN_LERR = 2;
   localparam int EN_TX = 1;
   localparam int EN_MODEM = 3;
   localparam int CFG_FIFO_EN = 0;
   localparam int CFG_PRE_LO = 1;
   localparam int CFG_HS_LO = 3;
   localparam int CFG_PIN_EN = 5;
   localparam int EV_LERR = 0;
   localparam int EV_TIMEOUT = 1;
   localparam int EV_TX = 2;
   localparam int EV_MODEM = 3;
   localparam logic [1:0] PRE_13 = 2'h0;
   localparam logic [1:0] PRE_1P625 = 2'h1;
   localparam logic [1:0] HS_ON = 2'h3;
   localparam logic [6:0] FRAC_STEP = 7'h08;
   localparam logic [6:0] FRAC_MOD_13 = 7'h68;
   localparam logic [6:0] FRAC_MOD_1P625 = 7'h0d;
   localparam logic [6:0] FRAC_MOD_1P0 = 7'h08;
   localparam int CHAR_TICKS = 160;
   localparam int TIMEOUT_CHARS = 4;
   localparam logic [9:0] TIMEOUT_TICKS = 10'(CHAR_TICKS * TIMEOUT_CHARS);
   localparam logic [3:0] ID_NONE = 4'h1;
   localparam logic [3:0] ID_LERR = 4'h6;
   localparam logic [3:0] ID_RX = 4'h4;
   localparam logic [3:0] ID_TIMEOUT = 4'hc;
   localparam logic [3:0] ID_TX = 4'h2;
   localparam logic [3:0] ID_MODEM = 4'h0;
   localparam logic [1:0] ID_FIFO_MARK = 2'h3;
   localparam logic [15:0] DIV_RESET = 16'h0000;

   typedef struct packed {
      logic [3:0] ier;
      logic [7:0] dll;
      logic [7:0] dlm;
      logic [7:0] scr;
      logic [5:0] cfg;
      logic [3:0] ev_status;
      logic [3:0] ev_mask;
      logic thre_pend;
      logic lerr_pend;
      logic tx_empty_prev;
      logic [9:0] to_cnt;
      logic to_pend;
      logic [6:0] frac_acc;
      logic [15:0] div_cnt;
      logic baud16;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic uart_irq;
      logic event_irq;
   } state_s;
endpackage : uart_irq_pkg

// ### tb/test_uart_irq_baud.sv
// Purpose: Self-checking bench for the serial port interrupt and baud block
// Assumes: ref_tick held high, so every clock is a reference tick, except in the last test
// Notes: A monitor checks each read against the oldest queued expectation
`timescale 1ns/1ns
`default_nettype none
module test_uart_irq_baud;
   import uart_irq_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
   logic pready, pslverr, baud16_tick, uart_irq, event_irq;
   logic ref_tick = 1'b1, line_error = 1'b0, line_status_read = 1'b0, rx_ready_level = 1'b0;
   logic rx_data_present = 1'b0, rx_fifo_access = 1'b0, tx_holding_empty = 1'b0, tx_holding_write = 1'b0;
   logic [3:0] modem_changed = 4'h0;
   logic [32:0] expq[$];
   logic ref_gap = 1'b0;
   logic [15:0] seed = 16'h41e6;
   int failures = 0, comparisons = 0, cycles = 0, k;
   always #2 clk = ~clk;
   uart_irq_baud uart_irq_baud_i (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_tick(ref_tick),
      .line_error(line_error), .line_status_read(line_status_read), .rx_ready_level(rx_ready_level),
      .rx_data_present(rx_data_present), .rx_fifo_access(rx_fifo_access), .tx_holding_empty(tx_holding_empty),
      .tx_holding_write(tx_holding_write), .modem_changed(modem_changed), .baud16_tick(baud16_tick),
      .uart_irq(uart_irq), .event_irq(event_irq));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic results;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results
   task automatic tick(input int c);
      repeat (c) @(posedge clk);
   endtask : tick
   // Every transfer queues its expected error flag and read word; held until pready is sampled
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      expq.push_back({(a > ADDR_EVM || a[1:0] != 2'h0), (w ? 32'h0 : d)});
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic per(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] hi, input int e);
      apb(1, ADDR_CFG, {24'h0, c});
      apb(1, ADDR_DLL, {24'h0, lo});
      apb(1, ADDR_DLM, {24'h0, hi});
      tick(600);
      k = 0;
      while (baud16_tick !== 1'b1 && k < 2000) begin
         @(posedge clk);
         k++;
      end
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (baud16_tick !== 1'b1 && k < 2000);
      check(k, e);
   endtask : per
   always @(posedge clk) begin
      if (ref_gap) ref_tick <= ~ref_tick;
      if (psel && penable && pready === 1'b1) begin
         if (expq.size() == 0) failures++;
         else check({pslverr, prdata}, expq.pop_front());
      end
      cycles++;
      if (cycles == 20000) begin
         failures++;
         results();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      apb(0, ADDR_IIR, 32'h01);
      apb(0, ADDR_DLL, 32'h0);
      apb(0, 8'h40, 32'h0);
      seed = lfsr(seed);
      apb(1, ADDR_SCR, {24'h0, seed[7:0]});
      apb(0, ADDR_SCR, {24'h0, seed[7:0]});
      apb(1, ADDR_IER, 32'hff);
      apb(0, ADDR_IER, 32'h0f);
      apb(1, ADDR_DLL, 32'ha5);
      apb(1, ADDR_DLM, 32'h3c);
      apb(0, ADDR_DLL, 32'ha5);
      apb(0, ADDR_DLM, 32'h3c);
      $display("registers done");
      apb(1, ADDR_CFG, 32'h21);
      tx_holding_empty <= 1'b1;
      modem_changed <= 4'h2;
      tick(2);
      apb(0, ADDR_IIR, 32'hc2);
      tick(2);
      check(uart_irq, 1'b1);
      rx_ready_level <= 1'b1;
      line_error <= 1'b1;
      tick(1);
      line_error <= 1'b0;
      tick(2);
      apb(0, ADDR_IIR, 32'hc6);
      line_status_read <= 1'b1;
      tick(1);
      line_status_read <= 1'b0;
      tick(2);
      apb(0, ADDR_IIR, 32'hc4);
      rx_ready_level <= 1'b0;
      tx_holding_empty <= 1'b0;
      tick(1);
      tx_holding_empty <= 1'b1;
      tick(2);
      apb(0, ADDR_IIR, 32'hc2);
      apb(0, ADDR_IIR, 32'hc0);
      apb(1, ADDR_IER, 32'h07);
      apb(0, ADDR_IIR, 32'hc1);
      apb(1, ADDR_IER, 32'h08);
      tx_holding_empty <= 1'b0;
      tick(2);
      tx_holding_empty <= 1'b1;
      tick(2);
      apb(0, ADDR_IIR, 32'hc0);
      apb(1, ADDR_CFG, 32'h01);
      tick(2);
      check(uart_irq, 1'b0);
      apb(1, ADDR_IER, 32'h00);
      apb(0, ADDR_IIR, 32'hc1);
      modem_changed <= 4'h0;
      tx_holding_write <= 1'b1;
      tick(1);
      tx_holding_write <= 1'b0;
      $display("priority done");
      apb(1, ADDR_EVS, 32'h0f);
      apb(1, ADDR_EVM, 32'h01);
      apb(0, ADDR_EVS, 32'h0);
      line_error <= 1'b1;
      tick(1);
      line_error <= 1'b0;
      tick(2);
      apb(0, ADDR_EVS, 32'h01);
      check(event_irq, 1'b1);
      apb(1, ADDR_EVS, 32'h01);
      apb(0, ADDR_EVS, 32'h0);
      tick(2);
      check(event_irq, 1'b0);
      $display("events done");
      apb(1, ADDR_CFG, 32'h38);
      apb(1, ADDR_DLL, 32'h01);
      apb(1, ADDR_DLM, 32'h00);
      apb(1, ADDR_IER, 32'h01);
      rx_data_present <= 1'b1;
      tick(700);
      apb(0, ADDR_IIR, 32'h01);
      apb(1, ADDR_CFG, 32'h39);
      tick(700);
      apb(0, ADDR_IIR, 32'hcc);
      apb(1, ADDR_IER, 32'h00);
      apb(0, ADDR_IIR, 32'hc1);
      rx_fifo_access <= 1'b1;
      rx_data_present <= 1'b0;
      tick(1);
      rx_fifo_access <= 1'b0;
      $display("timeout done");
      per(8'h04, 8'h00, 8'h01, 256);
      per(8'h00, 8'h02, 8'h00, 26);
      per(8'h04, 8'h00, 8'h00, 1);
      per(8'h18, 8'h05, 8'h00, 5);
      per(8'h08, 8'h01, 8'h00, 13);
      ref_gap <= 1'b1;
      apb(1, ADDR_CFG, 32'h02);
      tick(600);
      k = 0;
      repeat (2080) begin
         @(posedge clk);
         if (baud16_tick === 1'b1) k++;
      end
      check(k, 640);
      $display("baud done");
      results();
   end
endmodule : test_uart_irq_baud
`default_nettype wire
